// ---- prs_lock_ctl.sv ----
// lock bit with two-byte key sequence and one-way option
`timescale 1ns/1ps
`default_nettype none
module prs_lock_ctl (
    // clock and resets
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // lock register write
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    // configuration
    input  wire logic       i_one_way,
    // state
    output logic            o_locked,
    output logic            o_armed
);
    prs_pkg::prs_key_t key_state;
    prs_pkg::prs_key_t next_key;
    logic              set_once;

    wire want     = i_wdata[prs_pkg::LOCK_BIT];
    wire do_set   = i_we && key_state == prs_pkg::KEY_ARMED && want
                    && !(i_one_way && set_once);
    wire do_clear = i_we && key_state == prs_pkg::KEY_ARMED && !want
                    && !i_one_way;

    // any write out of order drops back to idle
    always_comb begin
        next_key = key_state;
        if (i_we) begin
            unique case (key_state)
                prs_pkg::KEY_IDLE:
                    next_key = (i_wdata == prs_pkg::KEY_FIRST) ?
                               prs_pkg::KEY_GOT1 : prs_pkg::KEY_IDLE;
                prs_pkg::KEY_GOT1:
                    next_key = (i_wdata == prs_pkg::KEY_SECOND) ?
                               prs_pkg::KEY_ARMED : prs_pkg::KEY_IDLE;
                prs_pkg::KEY_ARMED:
                    next_key = prs_pkg::KEY_IDLE;
                default:
                    next_key = prs_pkg::KEY_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            key_state <= prs_pkg::KEY_IDLE;
            o_locked  <= prs_pkg::LOCK_RST;
            set_once  <= 1'b0;
        end else begin
            key_state <= next_key;
            if (do_set) begin
                o_locked <= 1'b1;
                set_once <= 1'b1;
            end else if (do_clear) begin
                o_locked <= 1'b0;
            end
        end
    end

    assign o_armed = key_state == prs_pkg::KEY_ARMED;
endmodule : prs_lock_ctl
`default_nettype wire

// ---- prs_periph_model.sv ----
// behavioural model of the peripheral outputs feeding the pin router
`timescale 1ns/1ps
`default_nettype none
module prs_periph_model (
    // clock and hold
    input  wire logic        i_clk,
    input  wire logic        i_run,
    // peripheral outputs, bit n is source code n
    output logic      [35:0] o_out,
    output logic      [35:0] o_oe_ovr,
    output logic      [35:0] o_oe
);
    logic [3:0] step = 4'h0;
    // pattern advances only while the bench lets it run
    always @(posedge i_clk) begin
        if (i_run) begin
            step <= step + 4'h1;
        end
    end
    assign o_out = {9{step}};
    assign o_oe = {9{~step}};
    // i2c clock and data take over their own pin driver
    assign o_oe_ovr = 36'h0_7800_0000;
endmodule : prs_periph_model
`default_nettype wire

// ---- prs_pkg.sv ----
// package of constants for the peripheral pin output routing block
package prs_pkg;
    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int NUM_PINS    = 36;
    localparam int NUM_INSEL   = 33;
    localparam int SEL_W       = 6;
    localparam int PIN_IDX_W   = 6;
    localparam int NUM_SRC     = 36;
    // ---------------------------------------------------------------
    // output source codes
    // ---------------------------------------------------------------
    localparam logic [5:0] SRC_LATCH = 6'h00;
    localparam logic [5:0] SRC_MAX   = 6'h23;
    localparam logic [5:0] SRC_RSV_A = 6'h14;
    localparam logic [5:0] SRC_RSV_B = 6'h17;
    // ---------------------------------------------------------------
    // lock register key and field
    // ---------------------------------------------------------------
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam int         LOCK_BIT   = 0;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [5:0] OUT_SEL_RST = 6'h00;
    localparam logic       LOCK_RST    = 1'b0;
    // input select reset values, port in 5:3, pin in 2:0
    localparam logic [NUM_INSEL*6-1:0] IN_SEL_RST = {
        6'h0c, 6'h0e, 6'h0f, 6'h16, 6'h17, 6'h08, 6'h0a, 6'h09,
        6'h05, 6'h14, 6'h13, 6'h0f, 6'h0e, 6'h01, 6'h00, 6'h08,
        6'h13, 6'h0f, 6'h15, 6'h13, 6'h11, 6'h12, 6'h11, 6'h12,
        6'h0f, 6'h15, 6'h13, 6'h10, 6'h10, 6'h0d, 6'h10, 6'h04,
        6'h08};
    // ---------------------------------------------------------------
    // port letters, pin index = port*8 + bit
    // ---------------------------------------------------------------
    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_D = 3'h3;
    localparam logic [2:0] PORT_E = 3'h4;
    // lock key state
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_ARMED} prs_key_t;
endpackage : prs_pkg

// ---- prs_routing.sv ----
// peripheral pin output routing: per-pin source select, lock, resets
`timescale 1ns/1ps
`default_nettype none
module prs_routing (
    // clock and resets
    input  wire logic                         I_CLK,
    input  wire logic                         I_RESET,
    input  wire logic                         I_POR,
    // configuration
    input  wire logic                         I_ONE_WAY_LOCK_CONFIG,
    input  wire logic                         I_PKG_40PIN,
    // register write port (software)
    input  wire logic                         I_OUT_SEL_WE,
    input  wire logic [5:0]                   I_OUT_SEL_IDX,
    input  wire logic                         I_IN_SEL_WE,
    input  wire logic [5:0]                   I_IN_SEL_IDX,
    input  wire logic [5:0]                   I_SEL_WDATA,
    input  wire logic                         I_LOCK_WE,
    input  wire logic [7:0]                   I_LOCK_WDATA,
    // pin side controls
    input  wire logic [prs_pkg::NUM_PINS-1:0] I_PIN_OUTPUT_LATCH,
    input  wire logic [prs_pkg::NUM_PINS-1:0] I_PIN_DIRECTION_CONTROL,
    // peripheral outputs, bit n is source code n
    input  wire logic [prs_pkg::NUM_SRC-1:0]  I_PERIPH_OUT,
    input  wire logic [prs_pkg::NUM_SRC-1:0]  I_PERIPH_OE_OVR,
    input  wire logic [prs_pkg::NUM_SRC-1:0]  I_PERIPH_OE,
    // pin drive
    output logic      [prs_pkg::NUM_PINS-1:0] O_PIN_OUT,
    output logic      [prs_pkg::NUM_PINS-1:0] O_PIN_OE,
    // status
    output logic                              O_ROUTING_LOCKED_BIT,
    output logic                              O_KEY_ARMED,
    output logic [prs_pkg::NUM_PINS*6-1:0]    O_PIN_OUTPUT_SOURCE_SELECT,
    output logic [prs_pkg::NUM_INSEL*6-1:0]   O_PERIPHERAL_INPUT_SELECT
);
    // ---------------------------------------------------------------
    // lock control
    // ---------------------------------------------------------------
    logic locked;
    logic armed;
    wire  any_reset = I_RESET || I_POR;

    prs_lock_ctl u_lock (
        .i_clk     (I_CLK),
        .i_reset   (any_reset),
        .i_we      (I_LOCK_WE),
        .i_wdata   (I_LOCK_WDATA),
        .i_one_way (I_ONE_WAY_LOCK_CONFIG),
        .o_locked  (locked),
        .o_armed   (armed)
    );

    // ---------------------------------------------------------------
    // allowed port per source code, bits {E,D,C,B,A}
    // ---------------------------------------------------------------
    function automatic logic [4:0] allow28(input logic [5:0] c);
        logic [4:0] r;
        r = 5'h00;
        unique case (c)
            6'h00:                      r = 5'h07;
            6'h01, 6'h02, 6'h19, 6'h1a,
            6'h20, 6'h22, 6'h23:        r = 5'h05;
            6'h0d, 6'h0e:               r = 5'h02;
            6'h14, 6'h17:               r = 5'h00;
            default:                    r = (c <= 6'h23) ? 5'h06 : 5'h00;
        endcase
        return r;
    endfunction : allow28

    function automatic logic [4:0] allow40(input logic [5:0] c);
        logic [4:0] r;
        r = 5'h00;
        unique case (c)
            6'h00:                      r = 5'h1f;
            6'h01, 6'h02, 6'h22, 6'h23: r = 5'h05;
            6'h20, 6'h19:               r = 5'h09;
            6'h1a:                      r = 5'h11;
            6'h03, 6'h04, 6'h06, 6'h07, 6'h08, 6'h0d, 6'h0e, 6'h0f,
            6'h10, 6'h16, 6'h18, 6'h1d, 6'h1e:
                                        r = 5'h0a;
            6'h14, 6'h17:               r = 5'h00;
            default:                    r = (c <= 6'h23) ? 5'h06 : 5'h00;
        endcase
        return r;
    endfunction : allow40

    // ---------------------------------------------------------------
    // selection registers
    // ---------------------------------------------------------------
    logic [5:0] out_sel [prs_pkg::NUM_PINS];
    logic [5:0] in_sel  [prs_pkg::NUM_INSEL];

    // write is refused if the code may not reach the addressed port
    wire [2:0] wr_port  = I_OUT_SEL_IDX[5:3];
    wire [4:0] wr_allow = I_PKG_40PIN ? allow40(I_SEL_WDATA)
                                      : allow28(I_SEL_WDATA);
    wire       port_ok  = (wr_port <= prs_pkg::PORT_E) &&
                          wr_allow[wr_port];

    genvar g;
    generate
        for (g = 0; g < prs_pkg::NUM_PINS; g++) begin : g_out
            wire we = I_OUT_SEL_WE && port_ok &&
                      (I_OUT_SEL_IDX == 6'(g));
            prs_sel_reg #(
                .RST_VAL (prs_pkg::OUT_SEL_RST),
                .IS_OUT  (1'b1)
            ) u_reg (
                .i_clk    (I_CLK),
                .i_por    (I_POR),
                .i_we     (we),
                .i_wdata  (I_SEL_WDATA),
                .i_locked (locked),
                .o_val    (out_sel[g])
            );
        end
        for (g = 0; g < prs_pkg::NUM_INSEL; g++) begin : g_in
            // port field 5:3, pin field 2:0 stored as written
            wire we = I_IN_SEL_WE && (I_IN_SEL_IDX == 6'(g)) &&
                      (I_SEL_WDATA[5:3] <= prs_pkg::PORT_E);
            prs_sel_reg #(
                .RST_VAL (prs_pkg::IN_SEL_RST[g*6 +: 6]),
                .IS_OUT  (1'b0)
            ) u_reg (
                .i_clk    (I_CLK),
                .i_por    (I_POR),
                .i_we     (we),
                .i_wdata  (I_SEL_WDATA),
                .i_locked (locked),
                .o_val    (in_sel[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // output routing per pin
    // ---------------------------------------------------------------
    logic [prs_pkg::NUM_PINS-1:0]   next_out;
    logic [prs_pkg::NUM_PINS-1:0]   next_oe;
    logic [prs_pkg::NUM_PINS*6-1:0] out_flat;
    logic [prs_pkg::NUM_INSEL*6-1:0] in_flat;

    always_comb begin
        for (int p = 0; p < prs_pkg::NUM_PINS; p++) begin
            out_flat[p*6 +: 6] = out_sel[p];
            if (out_sel[p] == prs_pkg::SRC_LATCH) begin
                next_out[p] = I_PIN_OUTPUT_LATCH[p];
                next_oe[p]  = !I_PIN_DIRECTION_CONTROL[p];
            end else begin
                next_out[p] = I_PERIPH_OUT[out_sel[p]];
                next_oe[p]  = I_PERIPH_OE_OVR[out_sel[p]] ?
                              I_PERIPH_OE[out_sel[p]] :
                              !I_PIN_DIRECTION_CONTROL[p];
            end
        end
        for (int q = 0; q < prs_pkg::NUM_INSEL; q++) begin
            in_flat[q*6 +: 6] = in_sel[q];
        end
    end

    // ---------------------------------------------------------------
    // output registers
    // ---------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_POR) begin
            O_PIN_OUT <= '0;
            O_PIN_OE  <= '0;
        end else begin
            O_PIN_OUT <= next_out;
            O_PIN_OE  <= next_oe;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (any_reset) begin
            O_ROUTING_LOCKED_BIT       <= prs_pkg::LOCK_RST;
            O_KEY_ARMED                <= 1'b0;
        end else begin
            O_ROUTING_LOCKED_BIT       <= locked;
            O_KEY_ARMED                <= armed;
        end
    end

    // selections mirror the kept registers, no reset of their own
    always_ff @(posedge I_CLK) begin
        O_PIN_OUTPUT_SOURCE_SELECT <= out_flat;
        O_PERIPHERAL_INPUT_SELECT  <= in_flat;
    end
endmodule : prs_routing
`default_nettype wire

// ---- prs_routing_asserts.sv ----
// checker for the pin output routing block
`timescale 1ns/1ps
`default_nettype none
module prs_routing_asserts (
    // watched ports
    input wire logic         I_CLK,
    input wire logic         I_RESET,
    input wire logic         I_POR,
    input wire logic         I_ONE_WAY_LOCK_CONFIG,
    input wire logic         I_LOCK_WE,
    input wire logic [7:0]   I_LOCK_WDATA,
    input wire logic [35:0]  I_PIN_OUTPUT_LATCH,
    input wire logic [35:0]  I_PIN_DIRECTION_CONTROL,
    input wire logic [35:0]  I_PERIPH_OUT,
    input wire logic [35:0]  I_PERIPH_OE_OVR,
    input wire logic [35:0]  I_PERIPH_OE,
    input wire logic [35:0]  O_PIN_OUT,
    input wire logic [35:0]  O_PIN_OE,
    input wire logic         O_ROUTING_LOCKED_BIT,
    input wire logic         O_KEY_ARMED,
    input wire logic [215:0] O_PIN_OUTPUT_SOURCE_SELECT,
    input wire logic [197:0] O_PERIPHERAL_INPUT_SELECT
);
    // --------------------
    // helpers and properties
    // --------------------
    logic [3:0] rst_hist;
    wire        quiet;
    wire  [5:0] s8;
    wire        out8;
    wire        oe8;
    always_ff @(posedge I_CLK) rst_hist <= {rst_hist[2:0], I_RESET | I_POR};
    // no reset seen lately, so lock changes must come from software
    assign quiet = (rst_hist == 4'h0) && !I_RESET && !I_POR;
    assign s8 = O_PIN_OUTPUT_SOURCE_SELECT[53:48];
    assign out8 = (s8 == 6'h00) ? I_PIN_OUTPUT_LATCH[8] : I_PERIPH_OUT[s8];
    // the latch code never hands the driver to a peripheral
    assign oe8 = (s8 != 6'h00 && I_PERIPH_OE_OVR[s8]) ? I_PERIPH_OE[s8]
                                                      : !I_PIN_DIRECTION_CONTROL[8];
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_POR);
    sequence s_key;
        (I_LOCK_WE && I_LOCK_WDATA == 8'h55) ##1 !I_LOCK_WE
        ##1 (I_LOCK_WE && I_LOCK_WDATA == 8'haa);
    endsequence
    property p_key_arms;
        s_key |-> ##[1:3] O_KEY_ARMED;
    endproperty
    property p_lock_key;
        quiet && $changed(O_ROUTING_LOCKED_BIT) |-> $past(O_KEY_ARMED)
            || $past(O_KEY_ARMED, 2) || $past(O_KEY_ARMED, 3);
    endproperty
    property p_one_way;
        quiet && I_ONE_WAY_LOCK_CONFIG && O_ROUTING_LOCKED_BIT
            |=> O_ROUTING_LOCKED_BIT;
    endproperty
    property p_locked_hold;
        O_ROUTING_LOCKED_BIT [*4] |-> $stable(O_PIN_OUTPUT_SOURCE_SELECT)
            && $stable(O_PERIPHERAL_INPUT_SELECT);
    endproperty
    property p_rst_clear;
        I_RESET |-> ##[1:3] !O_ROUTING_LOCKED_BIT;
    endproperty
    property p_rst_keep;
        I_RESET && $past(I_RESET) |-> $stable(O_PIN_OUTPUT_SOURCE_SELECT)
            && $stable(O_PERIPHERAL_INPUT_SELECT);
    endproperty
    property p_por_default;
        $fell(I_POR) |-> ##[0:2] (O_PIN_OUTPUT_SOURCE_SELECT == 216'h0
            && O_PERIPHERAL_INPUT_SELECT == prs_pkg::IN_SEL_RST);
    endproperty
    property p_pin8;
        $stable({s8, out8, oe8}) [*3] |-> O_PIN_OUT[8] == out8
            && O_PIN_OE[8] == oe8;
    endproperty
    a_key_arms : assert property (p_key_arms)
        else $error("key pair did not arm");
    a_lock_key : assert property (p_lock_key)
        else $error("lock bit changed without key");
    a_one_way : assert property (p_one_way)
        else $error("one-way lock was cleared");
    a_locked_hold : assert property (p_locked_hold)
        else $error("selection changed while locked");
    a_rst_clear : assert property (p_rst_clear)
        else $error("lock bit survived reset");
    a_rst_keep : assert property (p_rst_keep)
        else $error("selection changed in plain reset");
    a_por_default : assert property (p_por_default)
        else $error("selections not at power-on defaults");
    a_pin8 : assert property (p_pin8)
        else $error("pin 8 drive does not follow its source");
endmodule : prs_routing_asserts
bind prs_routing prs_routing_asserts u_chk (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_POR(I_POR),
    .I_ONE_WAY_LOCK_CONFIG(I_ONE_WAY_LOCK_CONFIG),
    .I_LOCK_WE(I_LOCK_WE), .I_LOCK_WDATA(I_LOCK_WDATA),
    .I_PIN_OUTPUT_LATCH(I_PIN_OUTPUT_LATCH),
    .I_PIN_DIRECTION_CONTROL(I_PIN_DIRECTION_CONTROL),
    .I_PERIPH_OUT(I_PERIPH_OUT), .I_PERIPH_OE_OVR(I_PERIPH_OE_OVR),
    .I_PERIPH_OE(I_PERIPH_OE), .O_PIN_OUT(O_PIN_OUT), .O_PIN_OE(O_PIN_OE),
    .O_ROUTING_LOCKED_BIT(O_ROUTING_LOCKED_BIT), .O_KEY_ARMED(O_KEY_ARMED),
    .O_PIN_OUTPUT_SOURCE_SELECT(O_PIN_OUTPUT_SOURCE_SELECT),
    .O_PERIPHERAL_INPUT_SELECT(O_PERIPHERAL_INPUT_SELECT)
);
`default_nettype wire

// ---- prs_sel_reg.sv ----
// one routing selection register with lock and reset classes
`timescale 1ns/1ps
`default_nettype none
module prs_sel_reg #(
    parameter logic [5:0] RST_VAL = 6'h00,
    parameter logic       IS_OUT  = 1'b1
) (
    // clock and power-on reset
    input  wire logic       i_clk,
    input  wire logic       i_por,
    // write port
    input  wire logic       i_we,
    input  wire logic [5:0] i_wdata,
    input  wire logic       i_locked,
    // stored value
    output logic      [5:0] o_val
);
    // writes while locked are dropped silently
    wire       wr_ok = i_we && !i_locked;
    wire       code_ok = !IS_OUT ||
                         ((i_wdata <= prs_pkg::SRC_MAX) &&
                          (i_wdata != prs_pkg::SRC_RSV_A) &&
                          (i_wdata != prs_pkg::SRC_RSV_B));
    wire [5:0] next_val = wr_ok && code_ok ? i_wdata : o_val;

    // only power-on/brown-out restores; other resets and sleep keep it
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            o_val <= RST_VAL;
        end else begin
            o_val <= next_val;
        end
    end
endmodule : prs_sel_reg
`default_nettype wire

// ---- tb_prs_routing.sv ----
// self-checking bench for the pin output routing block
`timescale 1ns/1ps
`default_nettype none
module tb_prs_routing;
    // --------------------
    // signals, clock, instances
    // --------------------
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         por = 1'b1;
    logic         one_way = 1'b0;
    logic         pkg40 = 1'b1;
    logic         run = 1'b1;
    logic         owe = 1'b0;
    logic         iwe = 1'b0;
    logic         lwe = 1'b0;
    logic [5:0]   idx = 6'h00;
    logic [5:0]   wd = 6'h00;
    logic [7:0]   lwd = 8'h00;
    logic [35:0]  lat = 36'h5_a5a5_3c3c;
    logic [35:0]  dir = 36'h3_0f0f_00ff;
    logic [35:0]  p_out, p_ovr, p_oe, pin_out, pin_oe;
    logic         locked, armed;
    logic [215:0] osel;
    logic [197:0] isel;
    int           fails = 0;
    int           cmp_count = 0;
    int           cyc = 0;
    always #4 clk = ~clk;
    prs_periph_model peer (.i_clk(clk), .i_run(run), .o_out(p_out),
        .o_oe_ovr(p_ovr), .o_oe(p_oe));
    prs_routing uut (.I_CLK(clk), .I_RESET(rst), .I_POR(por),
        .I_ONE_WAY_LOCK_CONFIG(one_way), .I_PKG_40PIN(pkg40),
        .I_OUT_SEL_WE(owe), .I_OUT_SEL_IDX(idx), .I_IN_SEL_WE(iwe),
        .I_IN_SEL_IDX(idx), .I_SEL_WDATA(wd), .I_LOCK_WE(lwe),
        .I_LOCK_WDATA(lwd), .I_PIN_OUTPUT_LATCH(lat),
        .I_PIN_DIRECTION_CONTROL(dir), .I_PERIPH_OUT(p_out),
        .I_PERIPH_OE_OVR(p_ovr), .I_PERIPH_OE(p_oe), .O_PIN_OUT(pin_out),
        .O_PIN_OE(pin_oe), .O_ROUTING_LOCKED_BIT(locked),
        .O_KEY_ARMED(armed), .O_PIN_OUTPUT_SOURCE_SELECT(osel),
        .O_PERIPHERAL_INPUT_SELECT(isel));
    // --------------------
    // tasks
    // --------------------
    task automatic chk(input logic [215:0] got, input logic [215:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // kind 0 output select, 1 input select, 2 lock register
    task automatic wr(input int kind, input logic [5:0] a,
                      input logic [7:0] d);
        idx = a;
        wd = d[5:0];
        lwd = d;
        owe = (kind == 0);
        iwe = (kind == 1);
        lwe = (kind == 2);
        @(negedge clk);
        owe = 1'b0;
        iwe = 1'b0;
        lwe = 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic settle;
        repeat (4) @(negedge clk);
    endtask : settle
    task automatic key(input logic [7:0] d);
        // key writes are one idle cycle apart, no other lock write may slip in between
        wr(2, 6'h00, 8'h55);
        wr(2, 6'h00, 8'haa);
        chk(armed, 1'b1);
        wr(2, 6'h00, d);
        settle();
    endtask : key
    task automatic pulse;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        settle();
    endtask : pulse
    task automatic results;
        $display("comparisons=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    task automatic t_defaults;
        chk(osel, 216'h0);
        chk(isel, prs_pkg::IN_SEL_RST);
        chk(locked, 1'b0);
        chk(pin_out, lat);
        chk(pin_oe, 36'(~dir));
        $display("test defaults done");
    endtask : t_defaults
    task automatic t_route;
        int         pins [4] = '{8, 0, 9, 26};
        logic [5:0] codes [4] = '{6'h09, 6'h23, 6'h1b, 6'h0d};
        logic [5:0] bad [4] = '{6'h14, 6'h17, 6'h24, 6'h01};
        logic       e;
        for (int k = 0; k < 4; k++) begin
            wr(0, pins[k][5:0], {2'h0, codes[k]});
        end
        run = 1'b0;
        settle();
        for (int k = 0; k < 4; k++) begin
            e = p_ovr[codes[k]] ? p_oe[codes[k]] : ~dir[pins[k]];
            chk(osel[pins[k]*6 +: 6], codes[k]);
            chk(pin_out[pins[k]], p_out[codes[k]]);
            chk(pin_oe[pins[k]], e);
            wr(0, 6'h08, {2'h0, bad[k]});
        end
        wr(0, 6'h10, 8'h20);
        settle();
        chk(osel[53:48], 6'h09);
        chk(osel[101:96], 6'h00);
        pkg40 = 1'b0;
        wr(0, 6'h10, 8'h20);
        wr(1, 6'd22, 8'h09);
        wr(1, 6'd22, 8'h29);
        wr(1, 6'd0, 8'h0f);
        settle();
        pkg40 = 1'b1;
        chk(osel[101:96], 6'h20);
        chk(isel[137:132], 6'h09);
        chk(isel[5:0], 6'h0f);
        run = 1'b1;
        $display("test route done");
    endtask : t_route
    task automatic t_lock;
        wr(2, 6'h00, 8'h01);
        settle();
        chk(locked, 1'b0);
        key(8'h01);
        chk(locked, 1'b1);
        wr(0, 6'h08, 8'h05);
        wr(1, 6'd22, 8'h0a);
        settle();
        chk(osel[53:48], 6'h09);
        chk(isel[137:132], 6'h09);
        wr(2, 6'h00, 8'h55);
        wr(2, 6'h00, 8'h33);
        wr(2, 6'h00, 8'haa);
        wr(2, 6'h00, 8'h00);
        settle();
        chk(locked, 1'b1);
        key(8'h00);
        chk(locked, 1'b0);
        wr(0, 6'h08, 8'h05);
        key(8'h01);
        chk(osel[53:48], 6'h05);
        chk(locked, 1'b1);
        key(8'h00);
        chk(locked, 1'b0);
        $display("test lock done");
    endtask : t_lock
    task automatic t_one_way;
        one_way = 1'b1;
        pulse();
        key(8'h01);
        chk(locked, 1'b1);
        key(8'h00);
        chk(locked, 1'b1);
        pulse();
        chk(locked, 1'b0);
        chk(osel[53:48], 6'h05);
        key(8'h01);
        chk(locked, 1'b1);
        one_way = 1'b0;
        pulse();
        key(8'h01);
        por = 1'b1;
        repeat (2) @(negedge clk);
        por = 1'b0;
        settle();
        chk(locked, 1'b0);
        chk(osel, 216'h0);
        chk(isel, prs_pkg::IN_SEL_RST);
        $display("test one-way and resets done");
    endtask : t_one_way
    // --------------------
    // main sequence and watchdog
    // --------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            results();
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        por = 1'b0;
        settle();
        t_defaults();
        t_route();
        t_lock();
        t_one_way();
        results();
    end
endmodule : tb_prs_routing
`default_nettype wire
